/* core/stcrb_timer.sv */
// Sixteen-bit timer with capture, auto-reload and baud clock modes
//
// How it works
// - Count is 16 bits, seen by software as a low and a high byte.
// - Internal source counts system clock divided by one or twelve, per prescale.
// - External source counts each falling edge of the count pin.
// - Run bit low stops the timer whatever the other mode bits say.
// - Baud selects zero, capture select one and run: capture mode.
// - Trigger pin edges act only with trigger enable set, else ignored.
// - Enabled trigger edge in capture copies count to reload bytes, sets trigger flag.
// - Capture or reload mode: overflow from all ones (to zero in capture) sets overflow flag.
// - Baud selects zero, capture select zero and run: auto-reload mode.
// - Auto-reload overflow loads the reload value and keeps counting.
// - Auto-reload with enable: trigger edge reloads counter, sets trigger flag.
// - Either baud select gives baud mode, always auto-reload.
// - Baud overflow reloads, sets no flag, becomes a shift clock event.
// - Receive and transmit shift ticks are selected independently.
// - Baud mode internal source counts at system clock divided by two.
// - Baud mode external source counts count pin edges.
// - Baud mode with enable: trigger edge sets trigger flag.
// - Overflow pulses a conversion start trigger.
`timescale 1ns/1ps

module stcrb_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // External pins
    input wire logic ext_count_pin_i,
    input wire logic ext_trigger_pin_i,
    // Events to the serial port, converter and interrupt controller
    output logic rx_shift_tick_o,
    output logic tx_shift_tick_o,
    output logic adc_trigger_o,
    output logic irq_o
);
    import stcrb_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic prescale_q;
    logic irq_en_q;
    logic [15:0] count_q;
    logic [15:0] reload_q;
    logic [STCRB_PRE_W-1:0] pre_q;

    // Pin synchronisers and edge history
    logic cnt_s1_q, cnt_s2_q, cnt_prev_q;
    logic trg_s1_q, trg_s2_q, trg_prev_q;

    // ----------------------------------------------------------------
    // Decoded control
    // ----------------------------------------------------------------
    logic run;
    logic src_ext;
    logic ext_en;
    logic baud_sel;
    stcrb_mode_t mode;
    logic cnt_fall;
    logic trg_fall;
    logic pre_wrap;
    logic tick;
    logic ovf;
    logic trg_act;
    logic [STCRB_PRE_W-1:0] pre_last;

    // Write strobe decode
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_i && (addr_i == a);
    endfunction

    assign run = ctrl_q[STCRB_BIT_RUN];
    assign src_ext = ctrl_q[STCRB_BIT_SRC_SEL];
    assign ext_en = ctrl_q[STCRB_BIT_EXT_EN];
    assign baud_sel = ctrl_q[STCRB_BIT_RX_BAUD] | ctrl_q[STCRB_BIT_TX_BAUD];

    // Mode selection from run, baud selects and capture select
    always_comb begin
        if (!run) begin
            mode = STCRB_MODE_OFF;
        end else if (baud_sel) begin
            mode = STCRB_MODE_BAUD;
        end else if (ctrl_q[STCRB_BIT_CAP_RLD]) begin
            mode = STCRB_MODE_CAPTURE;
        end else begin
            mode = STCRB_MODE_RELOAD;
        end
    end

    // Falling edges seen on the synchronised pins
    assign cnt_fall = cnt_prev_q & ~cnt_s2_q;
    assign trg_fall = trg_prev_q & ~trg_s2_q;

    // Prescaler end value for divide by one, twelve, or two in baud mode
    always_comb begin
        if (mode == STCRB_MODE_BAUD) begin
            pre_last = STCRB_PRE_W'(STCRB_DIV_BAUD - 1);
        end else if (prescale_q) begin
            pre_last = '0;
        end else begin
            pre_last = STCRB_PRE_W'(STCRB_DIV_SLOW - 1);
        end
    end

    assign pre_wrap = (pre_q >= pre_last);

    // Count tick from the selected source, only while running
    always_comb begin
        if (mode == STCRB_MODE_OFF) begin
            tick = 1'b0;
        end else if (src_ext) begin
            tick = cnt_fall;
        end else begin
            tick = pre_wrap;
        end
    end

    assign ovf = tick && (count_q == STCRB_CNT_ALL_ONES);
    assign trg_act = trg_fall && ext_en && (mode != STCRB_MODE_OFF);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops per pin, then one more to find the edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_s1_q <= 1'b0;
            cnt_s2_q <= 1'b0;
            cnt_prev_q <= 1'b0;
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_prev_q <= 1'b0;
        end else begin
            cnt_s1_q <= ext_count_pin_i;
            cnt_s2_q <= cnt_s1_q;
            cnt_prev_q <= cnt_s2_q;
            trg_s1_q <= ext_trigger_pin_i;
            trg_s2_q <= trg_s1_q;
            trg_prev_q <= trg_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Free divider; held at zero while the timer is off
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q <= '0;
        end else if (mode == STCRB_MODE_OFF || src_ext || pre_wrap) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + STCRB_PRE_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Software writes win over counting in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= {STCRB_RST_BYTE, STCRB_RST_BYTE};
        end else if (wr_hit(STCRB_ADDR_CNT_LOW)) begin
            count_q[7:0] <= wdata_i;
        end else if (wr_hit(STCRB_ADDR_CNT_HIGH)) begin
            count_q[15:8] <= wdata_i;
        end else begin
            case (mode)
                STCRB_MODE_CAPTURE: begin
                    if (tick) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                STCRB_MODE_RELOAD: begin
                    if (ovf || trg_act) begin
                        count_q <= reload_q;
                    end else if (tick) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                STCRB_MODE_BAUD: begin
                    if (ovf) begin
                        count_q <= reload_q;
                    end else if (tick) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reload / capture bytes
    // ----------------------------------------------------------------
    // A capture edge overrides a software write in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reload_q <= {STCRB_RST_BYTE, STCRB_RST_BYTE};
        end else if (trg_act && mode == STCRB_MODE_CAPTURE) begin
            reload_q <= count_q;
        end else if (wr_hit(STCRB_ADDR_RLD_LOW)) begin
            reload_q[7:0] <= wdata_i;
        end else if (wr_hit(STCRB_ADDR_RLD_HIGH)) begin
            reload_q[15:8] <= wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Control register and flags
    // ----------------------------------------------------------------
    // Mode bits from software; flags set by hardware, set wins over clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= STCRB_RST_BYTE;
        end else begin
            if (wr_hit(STCRB_ADDR_TMR_CTRL)) begin
                ctrl_q <= wdata_i;
            end
            if (ovf && (mode == STCRB_MODE_CAPTURE || mode == STCRB_MODE_RELOAD)) begin
                ctrl_q[STCRB_BIT_OVF_FLAG] <= 1'b1;
            end
            if (trg_act) begin
                ctrl_q[STCRB_BIT_EXT_FLAG] <= 1'b1;
            end
        end
    end

    // Prescale select and interrupt enable
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prescale_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_hit(STCRB_ADDR_CLK_CTRL)) begin
                prescale_q <= wdata_i[STCRB_BIT_PRESCALE];
            end
            if (wr_hit(STCRB_ADDR_IRQ_EN)) begin
                irq_en_q <= wdata_i[STCRB_BIT_IRQ_EN];
            end
        end
    end

    // ----------------------------------------------------------------
    // Event outputs
    // ----------------------------------------------------------------
    // One-cycle pulses on overflow; interrupt level follows the flags
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_shift_tick_o <= 1'b0;
            tx_shift_tick_o <= 1'b0;
            adc_trigger_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            rx_shift_tick_o <= ovf && (mode == STCRB_MODE_BAUD) && ctrl_q[STCRB_BIT_RX_BAUD];
            tx_shift_tick_o <= ovf && (mode == STCRB_MODE_BAUD) && ctrl_q[STCRB_BIT_TX_BAUD];
            adc_trigger_o <= ovf;
            irq_o <= irq_en_q && (ctrl_q[STCRB_BIT_OVF_FLAG] || ctrl_q[STCRB_BIT_EXT_FLAG]);
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Data stands in the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= STCRB_RST_BYTE;
        end else if (rd_i) begin
            case (addr_i)
                STCRB_ADDR_TMR_CTRL: rdata_o <= ctrl_q;
                STCRB_ADDR_CLK_CTRL: rdata_o <= 8'(prescale_q) << STCRB_BIT_PRESCALE;
                STCRB_ADDR_IRQ_EN: rdata_o <= 8'(irq_en_q);
                STCRB_ADDR_RLD_LOW: rdata_o <= reload_q[7:0];
                STCRB_ADDR_RLD_HIGH: rdata_o <= reload_q[15:8];
                STCRB_ADDR_CNT_LOW: rdata_o <= count_q[7:0];
                STCRB_ADDR_CNT_HIGH: rdata_o <= count_q[15:8];
                default: rdata_o <= STCRB_RST_BYTE;
            endcase
        end else begin
            rdata_o <= STCRB_RST_BYTE;
        end
    end
endmodule

/* core/stcrb_pkg.sv */
// Constants for the sixteen-bit capture/reload/baud timer
package stcrb_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] STCRB_ADDR_CLK_CTRL = 8'h8e;
    localparam logic [7:0] STCRB_ADDR_TMR_CTRL = 8'hc8;
    localparam logic [7:0] STCRB_ADDR_RLD_LOW = 8'hca;
    localparam logic [7:0] STCRB_ADDR_RLD_HIGH = 8'hcb;
    localparam logic [7:0] STCRB_ADDR_CNT_LOW = 8'hcc;
    localparam logic [7:0] STCRB_ADDR_CNT_HIGH = 8'hcd;
    localparam logic [7:0] STCRB_ADDR_IRQ_EN = 8'hcf;

    // ----------------------------------------------------------------
    // Field positions of timer_ctrl_reg
    // ----------------------------------------------------------------
    localparam int STCRB_BIT_CAP_RLD = 0;
    localparam int STCRB_BIT_SRC_SEL = 1;
    localparam int STCRB_BIT_RUN = 2;
    localparam int STCRB_BIT_EXT_EN = 3;
    localparam int STCRB_BIT_TX_BAUD = 4;
    localparam int STCRB_BIT_RX_BAUD = 5;
    localparam int STCRB_BIT_EXT_FLAG = 6;
    localparam int STCRB_BIT_OVF_FLAG = 7;

    // Field positions of clock_ctrl_reg and the enable register
    localparam int STCRB_BIT_PRESCALE = 5;
    localparam int STCRB_BIT_IRQ_EN = 0;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] STCRB_RST_BYTE = 8'h00;
    localparam logic [15:0] STCRB_CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] STCRB_CNT_ZERO = 16'h0000;
    localparam int STCRB_DIV_SLOW = 12;
    localparam int STCRB_DIV_BAUD = 2;
    localparam int STCRB_PRE_W = 4;

    // Operating modes
    typedef enum logic [1:0] {
        STCRB_MODE_OFF,
        STCRB_MODE_CAPTURE,
        STCRB_MODE_RELOAD,
        STCRB_MODE_BAUD
    } stcrb_mode_t;
endpackage

/* verification/stcrb_timer_asserts.sv */
// Port-level checker for the capture/reload/baud timer
`timescale 1ns/1ps
module stcrb_timer_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Pins and events
    input wire logic ext_count_pin_i,
    input wire logic ext_trigger_pin_i,
    input wire logic rx_shift_tick_o,
    input wire logic tx_shift_tick_o,
    input wire logic adc_trigger_o,
    input wire logic irq_o
);
    import stcrb_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ----------------------------------------------------------------
    // Bus steps
    // ----------------------------------------------------------------
    sequence s_stop_clear;
        wr_i && addr_i == STCRB_ADDR_TMR_CTRL && wdata_i[7:6] == 2'b00 && !wdata_i[STCRB_BIT_RUN];
    endsequence
    sequence s_ctrl_read;
        rd_i && addr_i == STCRB_ADDR_TMR_CTRL;
    endsequence
    sequence s_rld_wr_rd;
        wr_i && addr_i == STCRB_ADDR_RLD_LOW ##2 rd_i && addr_i == STCRB_ADDR_RLD_LOW;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    chk_rx_pulse: assert property (rx_shift_tick_o |=> !rx_shift_tick_o)
        else $error("receive tick longer than one cycle");
    chk_tx_pulse: assert property (tx_shift_tick_o |=> !tx_shift_tick_o)
        else $error("transmit tick longer than one cycle");
    chk_tick_adc: assert property ((rx_shift_tick_o || tx_shift_tick_o) |-> adc_trigger_o)
        else $error("shift tick without conversion trigger");
    chk_irq_off: assert property (wr_i && addr_i == STCRB_ADDR_IRQ_EN && !wdata_i[0] |-> ##2 !irq_o)
        else $error("interrupt high after enable cleared");
    chk_flag_clear: assert property (s_stop_clear ##2 s_ctrl_read |=> rdata_o[7:6] == 2'b00)
        else $error("flags not cleared by software write");
    chk_run_stop: assert property (wr_i && addr_i == STCRB_ADDR_TMR_CTRL && !wdata_i[2] |-> ##3 !adc_trigger_o [*4])
        else $error("overflow while stopped");
    chk_reload_back: assert property (s_rld_wr_rd |=> rdata_o == $past(wdata_i, 3))
        else $error("reload low byte not held");
endmodule
bind stcrb_timer stcrb_timer_asserts u_stcrb_timer_asserts (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .ext_count_pin_i, .ext_trigger_pin_i, .rx_shift_tick_o, .tx_shift_tick_o, .adc_trigger_o, .irq_o);

/* verification/stcrb_far_model.sv */
// Far-side model: count and trigger pins, serial port shift clock inputs
`timescale 1ns/1ps
module stcrb_far_model (
    // Clock
    input wire logic clk_i,
    // Shift clock events from the timer
    input wire logic rx_tick_i,
    input wire logic tx_tick_i,
    // Pins toward the timer
    output logic count_pin_o,
    output logic trigger_pin_o
);
    int rx_n = 0;
    int tx_n = 0;
    // Pins idle high, as with a pull-up
    initial begin
        count_pin_o = 1'b1;
        trigger_pin_o = 1'b1;
    end
    // Serial port in a variable-rate mode takes each tick as a shift clock
    always @(posedge clk_i) begin
        if (rx_tick_i) rx_n <= rx_n + 1;
        if (tx_tick_i) tx_n <= tx_n + 1;
    end
    // Falling edges, three cycles low then three or more high
    task pulse(input bit trig, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (trig) trigger_pin_o <= 1'b0;
            else count_pin_o <= 1'b0;
            repeat (3) @(posedge clk_i);
            trigger_pin_o <= 1'b1;
            count_pin_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule

/* verification/tb_stcrb_timer.sv */
// Self-checking testbench for the capture/reload/baud timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_stcrb_timer;
    import stcrb_pkg::*;
    localparam logic [7:0] CT = STCRB_ADDR_TMR_CTRL;
    localparam logic [7:0] CL = STCRB_ADDR_CNT_LOW;
    localparam logic [7:0] CH = STCRB_ADDR_CNT_HIGH;
    localparam logic [7:0] RL = STCRB_ADDR_RLD_LOW;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic cnt_pin, trg_pin, rx_tick, tx_tick, adc_trigger_o, irq_o;
    int err_count = 0;
    int comparisons = 0;
    // ----------------------------------------------------------------
    // Design and far side
    // ----------------------------------------------------------------
    stcrb_timer u_stcrb_timer (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ext_count_pin_i(cnt_pin), .ext_trigger_pin_i(trg_pin), .rx_shift_tick_o(rx_tick),
        .tx_shift_tick_o(tx_tick), .adc_trigger_o, .irq_o);
    stcrb_far_model u_stcrb_far_model (.clk_i, .rx_tick_i(rx_tick), .tx_tick_i(tx_tick),
        .count_pin_o(cnt_pin), .trigger_pin_o(trg_pin));
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // Bus tasks and period measurement
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        `CHK($sformatf("reg %h", a), e, rdata_o)
    endtask
    // Cycles between two conversion triggers
    task gap(input int e);
        int n;
        n = 0;
        while (adc_trigger_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (adc_trigger_o !== 1'b1 && n < 400);
        `CHK("period", e, n)
    endtask
    task summarize();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (8000) @(posedge clk_i);
        err_count++;
        summarize();
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(CT, 8'h00);
        rd(CH, 8'h00);
        rd(8'h00, 8'h00);
        wr(STCRB_ADDR_IRQ_EN, 8'h01);
        wr(CL, 8'h34);
        wr(CH, 8'h12);
        wr(CT, 8'h0f);
        u_stcrb_far_model.pulse(1'b0, 3);
        rd(CL, 8'h37);
        u_stcrb_far_model.pulse(1'b1, 1);
        rd(RL, 8'h37);
        rd(STCRB_ADDR_RLD_HIGH, 8'h12);
        rd(CT, 8'h4f);
        `CHK("irq", 1'b1, irq_o)
        wr(CT, 8'h07);
        u_stcrb_far_model.pulse(1'b1, 1);
        rd(CT, 8'h07);
        wr(CL, 8'hfe);
        wr(CH, 8'hff);
        u_stcrb_far_model.pulse(1'b0, 2);
        rd(CH, 8'h00);
        rd(CT, 8'h87);
        wr(CT, 8'h0a);
        rd(CT, 8'h0a);
        u_stcrb_far_model.pulse(1'b0, 2);
        rd(CL, 8'h00);
        wr(RL, 8'hf0);
        rd(RL, 8'hf0);
        wr(STCRB_ADDR_RLD_HIGH, 8'hff);
        wr(CL, 8'hfe);
        wr(CH, 8'hff);
        wr(CT, 8'h0e);
        u_stcrb_far_model.pulse(1'b0, 2);
        rd(CL, 8'hf0);
        rd(CT, 8'h8e);
        u_stcrb_far_model.pulse(1'b0, 1);
        u_stcrb_far_model.pulse(1'b1, 1);
        rd(CL, 8'hf0);
        rd(CT, 8'hce);
        wr(CT, 8'h3e);
        wr(CL, 8'hfe);
        u_stcrb_far_model.pulse(1'b0, 2);
        rd(CT, 8'h3e);
        rd(CL, 8'hf0);
        `CHK("rx ticks", 1, u_stcrb_far_model.rx_n)
        wr(CT, 8'h1f);
        u_stcrb_far_model.pulse(1'b0, 16);
        rd(CL, 8'hf0);
        `CHK("tx ticks", 2, u_stcrb_far_model.tx_n)
        `CHK("rx ticks", 1, u_stcrb_far_model.rx_n)
        u_stcrb_far_model.pulse(1'b1, 1);
        rd(CT, 8'h5f);
        wr(STCRB_ADDR_IRQ_EN, 8'h00);
        repeat (2) @(negedge clk_i);
        `CHK("irq", 1'b0, irq_o)
        wr(STCRB_ADDR_CLK_CTRL, 8'h20);
        wr(CT, 8'h04);
        gap(16);
        wr(STCRB_ADDR_CLK_CTRL, 8'h00);
        gap(192);
        wr(CT, 8'h14);
        gap(32);
        wr(CT, 8'h00);
        summarize();
    end
endmodule
